// [core/ctp_consts.svh]
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH
`define CTP_NCH 8
`define CTP_ADDR_SEL 8'hF7
`define CTP_ADDR_EN 8'hF6
`define CTP_CM_PAGE 4'h2
`define CTP_ADDR_REL_LO 8'h30
`define CTP_ADDR_REL_HI 8'h31
`define CTP_ADDR_CTRL 8'h32
`define CTP_ADDR_CLRP 8'h33
`define CTP_ADDR_CNT_LO 8'h34
`define CTP_ADDR_CNT_HI 8'h35
`define CTP_PSC_LSB 0
`define CTP_PSC_MSB 2
`define CTP_FLAG_BIT 3
`define CTP_RUN_BIT 4
`define CTP_RST_BYTE 8'h00
`define CTP_RST_WORD 16'h0000
`define CTP_ALL_ONES 16'hFFFF
`define CTP_ONE_WORD 16'h0001
`define CTP_ONE_BYTE 8'h01
`define CTP_RST_PSC 3'h0
`endif

// [core/ctp_pkg.sv]
package ctp_pkg;
  typedef logic [7:0] ctp_byte_type;
  typedef logic [15:0] ctp_word_type;
  typedef enum logic [1:0] {
    CTP_IDLE = 2'b01,
    CTP_RUN = 2'b10
  } ctp_tmr_state_type;
endpackage : ctp_pkg

// [core/ctp_channel.sv]
`timescale 1ns/1ps
`include "ctp_consts.svh"
module ctp_channel (
  input logic i_ref_clk,
  input logic i_nrst,
  input logic i_wr_lo,
  input logic i_wr_hi,
  input ctp_pkg::ctp_byte_type i_wdata,
  input logic i_sel,
  input logic i_en,
  input logic i_en_rise,
  input logic i_clr,
  input logic i_tick,
  input logic i_ovf,
  input ctp_pkg::ctp_word_type i_count_n,
  output ctp_pkg::ctp_word_type o_reg_latch,
  output logic o_out
);
  import ctp_pkg::*;

  ctp_word_type reg_q;
  ctp_word_type active_q;
  ctp_word_type active_n;
  logic arm_q;
  logic load;

  // The overflow load uses the latch content from before a same-cycle write.
  assign load = i_sel && i_ovf && arm_q;
  assign o_reg_latch = reg_q;

  always_comb begin
    active_n = load ? reg_q : active_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      reg_q <= `CTP_RST_WORD;
    end else if (i_wr_lo) begin
      reg_q[7:0] <= i_wdata;
    end else if (i_wr_hi) begin
      reg_q[15:8] <= i_wdata;
    end
  end

  // A low byte write in the overflow cycle keeps the arm set for the next overflow.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      arm_q <= 1'b0;
    end else if (i_wr_lo && i_sel) begin
      arm_q <= 1'b1;
    end else if (load) begin
      arm_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      active_q <= `CTP_RST_WORD;
    end else if (!i_sel && i_wr_lo) begin
      active_q <= {reg_q[15:8], i_wdata};
    end else if (load) begin
      active_q <= reg_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_out <= 1'b0;
    end else if (!i_en || i_en_rise || i_clr) begin
      o_out <= 1'b0;
    end else if (i_sel && i_tick) begin
      if (i_count_n == active_n) begin
        o_out <= 1'b1;
      end else if (i_ovf) begin
        o_out <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  property p_toc_load;
    load |=> active_q == $past(reg_q);
  endproperty
  a_toc_load: assert property (p_toc_load)
    else $error("overflow load did not copy the register latch");

  property p_no_direct;
    (i_sel && !load) |=> active_q == $past(active_q);
  endproperty
  a_no_direct: assert property (p_no_direct)
    else $error("active latch changed without an overflow load");

  property p_unarmed;
    (i_sel && i_ovf && !arm_q) |=> $stable(active_q);
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("active latch loaded without a low byte write");

  property p_mode1;
    (!i_sel && i_wr_lo) |=>
      active_q == {$past(reg_q[15:8]), $past(i_wdata)};
  endproperty
  a_mode1: assert property (p_mode1)
    else $error("mode 1 low byte write not loaded directly");

  property p_all_ones;
    (i_sel && i_en && !i_en_rise && !i_clr && i_tick &&
     i_count_n == `CTP_ALL_ONES && active_n == `CTP_ALL_ONES)
      |=> o_out;
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("all ones compare value gave no end spike");

  c_load: cover property (load);
endmodule : ctp_channel

// [core/ctp_compare_pwm.sv]
`timescale 1ns/1ps
`include "ctp_consts.svh"
module ctp_compare_pwm (
  input logic i_ref_clk,
  input logic i_nrst,
  input ctp_pkg::ctp_byte_type i_addr,
  input ctp_pkg::ctp_byte_type i_wdata,
  input logic i_wr,
  input logic i_rd,
  output ctp_pkg::ctp_byte_type o_rdata,
  output logic [`CTP_NCH-1:0] o_cmp_pin,
  output logic [`CTP_NCH-1:0] o_cmp_oe,
  output logic o_overflow_flag,
  output ctp_pkg::ctp_tmr_state_type o_timer_state
);
  import ctp_pkg::*;

  // Returns {hit, channel index} for the compare value byte window.
  function automatic logic [3:0] cm_decode(input ctp_byte_type a);
    cm_decode = {(a[7:4] == `CTP_CM_PAGE), a[3:1]};
  endfunction : cm_decode

  ctp_byte_type sel_q;
  ctp_byte_type en_q;
  ctp_word_type reload_q;
  ctp_word_type count_q;
  ctp_word_type count_n;
  logic [2:0] psc_q;
  ctp_byte_type pre_q;
  ctp_byte_type pre_lim;
  ctp_tmr_state_type state_q;
  logic running;
  logic tick;
  logic ovf;
  logic flag_q;
  logic start;
  logic wr_ctrl;
  logic [3:0] wdec;
  logic [3:0] rdec;
  ctp_byte_type rd_d;
  ctp_word_type reg_latch [`CTP_NCH];
  logic [`CTP_NCH-1:0] wr_lo;
  logic [`CTP_NCH-1:0] wr_hi;
  logic [`CTP_NCH-1:0] en_rise;
  logic [`CTP_NCH-1:0] clr;

  assign wdec = cm_decode(i_addr);
  assign rdec = cm_decode(i_addr);
  assign running = (state_q == CTP_RUN);
  assign start = i_wr && (i_addr == `CTP_ADDR_REL_LO);
  assign wr_ctrl = i_wr && (i_addr == `CTP_ADDR_CTRL);

  // Prescaler divides the machine-state rate by two to the power psc_q.
  assign pre_lim = 8'((`CTP_ONE_BYTE << psc_q) - `CTP_ONE_BYTE);
  assign tick = running && (pre_q == pre_lim) && !start;
  assign ovf = tick && (count_q == `CTP_ALL_ONES);
  assign count_n = ovf ? reload_q : 16'(count_q + `CTP_ONE_WORD);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      sel_q <= `CTP_RST_BYTE;
    end else if (i_wr && i_addr == `CTP_ADDR_SEL) begin
      sel_q <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      en_q <= `CTP_RST_BYTE;
    end else if (i_wr && i_addr == `CTP_ADDR_EN) begin
      en_q <= i_wdata;
    end
  end

  // The pin enable follows the enable bit so the pin carries the compare.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_cmp_oe <= `CTP_RST_BYTE;
    end else if (i_wr && i_addr == `CTP_ADDR_EN) begin
      o_cmp_oe <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      psc_q <= `CTP_RST_PSC;
    end else if (wr_ctrl) begin
      psc_q <= i_wdata[`CTP_PSC_MSB:`CTP_PSC_LSB];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      reload_q <= `CTP_RST_WORD;
    end else if (start) begin
      reload_q[7:0] <= i_wdata;
    end else if (i_wr && i_addr == `CTP_ADDR_REL_HI) begin
      reload_q[15:8] <= i_wdata;
    end
  end

  // A reload write restarts the prescaler so the first period is whole.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      pre_q <= `CTP_RST_BYTE;
    end else if (start || tick || pre_q >= pre_lim) begin
      pre_q <= `CTP_RST_BYTE;
    end else if (running) begin
      pre_q <= 8'(pre_q + `CTP_ONE_BYTE);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state_q <= CTP_IDLE;
    end else begin
      case (state_q)
        CTP_IDLE: begin
          if (start) begin
            state_q <= CTP_RUN;
          end
        end
        CTP_RUN: begin
          state_q <= CTP_RUN;
        end
        default: begin
          state_q <= CTP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_timer_state <= CTP_IDLE;
    end else if (start) begin
      o_timer_state <= CTP_RUN;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      count_q <= `CTP_RST_WORD;
    end else if (start) begin
      count_q <= {reload_q[15:8], i_wdata};
    end else if (tick) begin
      count_q <= count_n;
    end
  end

  // Writing the control byte with the flag bit at zero clears the flag.
  // An overflow in the same cycle wins so no period start is missed.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      flag_q <= 1'b0;
    end else if (ovf) begin
      flag_q <= 1'b1;
    end else if (wr_ctrl && !i_wdata[`CTP_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_overflow_flag <= 1'b0;
    end else if (ovf) begin
      o_overflow_flag <= 1'b1;
    end else if (wr_ctrl && !i_wdata[`CTP_FLAG_BIT]) begin
      o_overflow_flag <= 1'b0;
    end
  end

  // The channels expose no request line; software polls or uses the flag.
  genvar gi;
  generate
    for (gi = 0; gi < `CTP_NCH; gi++) begin : g_ch
      assign wr_lo[gi] = i_wr && wdec[3] && (wdec[2:0] == 3'(gi)) &&
                         !i_addr[0];
      assign wr_hi[gi] = i_wr && wdec[3] && (wdec[2:0] == 3'(gi)) &&
                         i_addr[0];
      assign en_rise[gi] = i_wr && (i_addr == `CTP_ADDR_EN) &&
                           i_wdata[gi] && !en_q[gi];
      assign clr[gi] = i_wr && (i_addr == `CTP_ADDR_CLRP) && i_wdata[gi];
      ctp_channel u_ch (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_wr_lo(wr_lo[gi]),
        .i_wr_hi(wr_hi[gi]),
        .i_wdata(i_wdata),
        .i_sel(sel_q[gi]),
        .i_en(en_q[gi]),
        .i_en_rise(en_rise[gi]),
        .i_clr(clr[gi]),
        .i_tick(tick),
        .i_ovf(ovf),
        .i_count_n(count_n),
        .o_reg_latch(reg_latch[gi]),
        .o_out(o_cmp_pin[gi])
      );
    end
  endgenerate

  always_comb begin
    rd_d = `CTP_RST_BYTE;
    if (rdec[3]) begin
      rd_d = i_addr[0] ? reg_latch[rdec[2:0]][15:8] :
                         reg_latch[rdec[2:0]][7:0];
    end else begin
      case (i_addr)
        `CTP_ADDR_SEL: rd_d = sel_q;
        `CTP_ADDR_EN: rd_d = en_q;
        `CTP_ADDR_REL_LO: rd_d = reload_q[7:0];
        `CTP_ADDR_REL_HI: rd_d = reload_q[15:8];
        `CTP_ADDR_CTRL: begin
          rd_d[`CTP_PSC_MSB:`CTP_PSC_LSB] = psc_q;
          rd_d[`CTP_FLAG_BIT] = flag_q;
          rd_d[`CTP_RUN_BIT] = running;
        end
        `CTP_ADDR_CNT_LO: rd_d = count_q[7:0];
        `CTP_ADDR_CNT_HI: rd_d = count_q[15:8];
        default: rd_d = `CTP_RST_BYTE;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_rdata <= `CTP_RST_BYTE;
    end else if (i_rd) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= `CTP_RST_BYTE;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  property p_tick_rate;
    (running && psc_q == `CTP_RST_PSC && !start && !wr_ctrl) |=>
      (count_q == 16'($past(count_q) + `CTP_ONE_WORD) ||
       count_q == $past(reload_q));
  endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("timer did not advance once per machine state");

  property p_flag;
    ovf |=> flag_q && o_overflow_flag;
  endproperty
  a_flag: assert property (p_flag)
    else $error("overflow did not set the flag");

  property p_ovf_reload;
    (ovf && !start) |=> count_q == $past(reload_q);
  endproperty
  a_ovf_reload: assert property (p_ovf_reload)
    else $error("overflow did not reload the timer");

  property p_start;
    start |=> running && count_q == {$past(reload_q[15:8]), $past(i_wdata)};
  endproperty
  a_start: assert property (p_start)
    else $error("reload write did not start the timer");

  property p_en_low;
    (i_wr && i_addr == `CTP_ADDR_EN && i_wdata[0] && !en_q[0])
      |=> !o_cmp_pin[0] && o_cmp_oe[0];
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("enabling channel 0 did not force its output low");

  property p_off_low;
    !en_q[0] |=> !o_cmp_pin[0];
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("disabled channel 0 drives its output high");

  property p_rd_once;
    i_rd ##1 !i_rd |=> o_rdata == `CTP_RST_BYTE;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data held past its cycle");

  property p_sel_read;
    (i_rd && i_addr == `CTP_ADDR_SEL) |=> o_rdata == $past(sel_q);
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("select register read back wrong");

  c_ovf: cover property (ovf ##1 flag_q);
  c_pin_rise: cover property (!o_cmp_pin[0] ##1 o_cmp_pin[0]);
  c_start: cover property (start ##1 running);
endmodule : ctp_compare_pwm

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import ctp_pkg::*;
  logic i_ref_clk;
  logic i_nrst;
  logic i_wr;
  logic i_rd;
  ctp_byte_type i_addr;
  ctp_byte_type i_wdata;
  ctp_byte_type o_rdata;
  logic [7:0] o_cmp_pin;
  logic [7:0] o_cmp_oe;
  logic o_overflow_flag;
  ctp_tmr_state_type o_timer_state;
  int n_errors;
  int num_checks;
  // Reference copy of the block, advanced on the same edges as the design.
  ctp_word_type m_reg [8];
  ctp_word_type m_act [8];
  ctp_word_type m_cnt;
  ctp_word_type m_rel;
  logic [7:0] m_sel, m_en, m_arm, m_pin;
  ctp_byte_type m_rd;
  logic m_run, m_flag;

  ctp_compare_pwm dut (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_cmp_pin(o_cmp_pin),
    .o_cmp_oe(o_cmp_oe),
    .o_overflow_flag(o_overflow_flag),
    .o_timer_state(o_timer_state)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  function automatic ctp_byte_type rd_val(ctp_byte_type a);
    if (a >= 8'h20 && a <= 8'h2F) begin
      return a[0] ? m_reg[a[3:1]][15:8] : m_reg[a[3:1]][7:0];
    end
    case (a)
      8'hF7: return m_sel;
      8'hF6: return m_en;
      8'h30: return m_rel[7:0];
      8'h31: return m_rel[15:8];
      8'h32: return {3'b000, m_run, m_flag, 3'b000};
      8'h34: return m_cnt[7:0];
      8'h35: return m_cnt[15:8];
      default: return 8'h00;
    endcase
  endfunction : rd_val

  always @(posedge i_ref_clk) begin : mirror
    logic tk;
    logic ov;
    ctp_word_type nc;
    ctp_word_type na;
    tk = m_run && !(i_wr && i_addr == 8'h30);
    ov = tk && m_cnt == 16'hFFFF;
    nc = ov ? m_rel : m_cnt + 16'h0001;
    m_rd <= i_rd ? rd_val(i_addr) : 8'h00;
    if (!i_nrst) begin
      for (int x = 0; x < 8; x++) begin
        m_reg[x] <= 16'h0000;
        m_act[x] <= 16'h0000;
      end
      m_cnt <= 16'h0000;
      m_rel <= 16'h0000;
      {m_sel, m_en, m_arm, m_pin} <= 32'h0000_0000;
      m_run <= 1'b0;
      m_flag <= 1'b0;
    end else begin
      if (tk) m_cnt <= nc;
      if (ov) begin
        m_flag <= 1'b1;
      end else if (i_wr && i_addr == 8'h32 && !i_wdata[3]) begin
        m_flag <= 1'b0;
      end
      for (int x = 0; x < 8; x++) begin
        na = (ov && m_sel[x] && m_arm[x]) ? m_reg[x] : m_act[x];
        m_act[x] <= na;
        if (ov && m_sel[x]) m_arm[x] <= 1'b0;
        if (!m_en[x] || (i_wr && i_addr == 8'h33 && i_wdata[x])) begin
          m_pin[x] <= 1'b0;
        end else if (m_sel[x] && tk) begin
          if (nc == na) m_pin[x] <= 1'b1;
          else if (ov) m_pin[x] <= 1'b0;
        end
        if (i_wr && i_addr == ctp_byte_type'(8'h20 + 2 * x)) begin
          m_reg[x][7:0] <= i_wdata;
          if (m_sel[x]) m_arm[x] <= 1'b1;
          else m_act[x] <= {m_reg[x][15:8], i_wdata};
        end
        if (i_wr && i_addr == ctp_byte_type'(8'h21 + 2 * x)) begin
          m_reg[x][15:8] <= i_wdata;
        end
      end
      if (i_wr && i_addr == 8'hF7) m_sel <= i_wdata;
      if (i_wr && i_addr == 8'hF6) m_en <= i_wdata;
      if (i_wr && i_addr == 8'h31) m_rel[15:8] <= i_wdata;
      if (i_wr && i_addr == 8'h30) begin
        m_rel[7:0] <= i_wdata;
        m_cnt <= {m_rel[15:8], i_wdata};
        m_run <= 1'b1;
      end
    end
  end

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic wr(ctp_byte_type a, ctp_byte_type d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(ctp_byte_type a);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask : rd

  task automatic rd_map();
    for (int a = 8'h1E; a < 8'h38; a++) rd(ctp_byte_type'(a));
    rd(8'hF6);
    rd(8'hF7);
  endtask : rd_map

  task automatic rnd_op();
    int k;
    int x;
    k = $urandom_range(9);
    x = $urandom_range(7);
    case (k)
      0, 1: wr(ctp_byte_type'(8'h20 + 2 * x), ctp_byte_type'(8'hE0 | $urandom_range(31)));
      2: wr(ctp_byte_type'(8'h21 + 2 * x), ($urandom_range(3) != 0) ? 8'hFF : 8'hFE);
      3: wr(8'hF6, ctp_byte_type'($urandom_range(255)));
      4: wr(8'h33, ctp_byte_type'(1 << x));
      5: wr(8'h32, ctp_byte_type'($urandom_range(1) << 3));
      6: wr(8'h30, ctp_byte_type'(8'hE0 | $urandom_range(31)));
      7: rd(ctp_byte_type'($urandom_range(255)));
      default: rd(ctp_byte_type'(8'h20 + $urandom_range(21)));
    endcase
  endtask : rnd_op

  initial begin
    @(posedge i_ref_clk);
    forever begin
      @(negedge i_ref_clk);
      chk("pins", o_cmp_pin, m_pin);
      chk("oe", o_cmp_oe, m_en);
      chk("flag", o_overflow_flag, m_flag);
      chk("state", o_timer_state, m_run ? CTP_RUN : CTP_IDLE);
      chk("rdata", o_rdata, m_rd);
    end
  end

  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    void'($urandom(86097));
    repeat (10) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd_map();
    // Preload active latches through mode 1, then arm a second value.
    wr(8'h21, 8'hFF);
    wr(8'h20, 8'hFE);
    wr(8'h23, 8'hFF);
    wr(8'h22, 8'hFF);
    wr(8'h25, 8'hFF);
    wr(8'h24, 8'hFC);
    wr(8'hF7, 8'h07);
    wr(8'h21, 8'hFF);
    wr(8'h20, 8'hFD);
    wr(8'h27, 8'hFF);
    wr(8'hF6, 8'h07);
    wr(8'h32, 8'h00);
    wr(8'h33, 8'h07);
    wr(8'h31, 8'hFF);
    wr(8'h30, 8'hFC);
    repeat (40) @(posedge i_ref_clk);
    rd_map();
    wr(8'h26, 8'hFE);
    repeat (12) @(posedge i_ref_clk);
    wr(8'hF7, 8'hFF);
    wr(8'hF6, 8'hFF);
    wr(8'h30, 8'hE8);
    for (int i = 0; i < 3000; i++) rnd_op();
    // A reset in mid-run must bring everything back to its start state.
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd_map();
    conclude();
  end
endmodule : tb_top
